// ==== hdl/uatx_pkg.sv ====
// uatx_pkg: constants and types for the serial transmit path
package uatx_pkg;
	// register bus geometry
	localparam int AW = 8;
	localparam int DW = 16;
	// register offsets (byte addresses)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_TX = 8'h04;
	localparam logic [7:0] ADDR_MISC = 8'h08;
	localparam logic [7:0] ADDR_LEVEL = 8'h0c;
	localparam logic [7:0] ADDR_TXCFG = 8'h10;
	// port_control_reg fields
	localparam int CT_PORT_EN = 0;
	localparam int CT_TX_EN = 1;
	localparam int CT_IR = 2;
	localparam int CT_PAR_EN = 3;
	localparam int CT_PAR_ODD = 4;
	localparam int CT_FLOW_IE = 5;
	localparam int CT_EMPTY_IE = 6;
	localparam int CT_HALF_IE = 7;
	localparam int CT_SPACE_IE = 8;
	localparam int CT_CLK_OUT = 9;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	// misc_reg fields
	localparam int MS_RX_INV = 0;
	localparam int MS_TX_INV = 1;
	localparam int MS_RTS_LEVEL = 2;
	localparam int MS_RTS_MANUAL = 3;
	localparam int MS_PERR = 4;
	localparam logic [4:0] MISC_RESET = 5'h00;
	// txcfg fields; writing one to the clear bit clears the change flag
	localparam int TC_BREAK = 0;
	localparam int TC_BYPASS = 1;
	localparam int TC_FLAG_CLR = 2;
	// transmit_reg read-back fields
	localparam int ST_SPACE = 0;
	localparam int ST_BUSY = 1;
	localparam int ST_CTS = 2;
	localparam int ST_FLAG = 3;
	localparam int ST_EMPTY = 4;
	localparam int ST_HALF = 5;
	localparam int ST_CNT = 8;
	// fifo depths and thresholds
	localparam int DEPTH_FIRST = 8;
	localparam int DEPTH_SECOND = 64;
	localparam logic [6:0] HALF_FIRST = 7'h04;
	localparam logic [6:0] RX_FREE_WARN = 7'h04;
	localparam logic [5:0] LEVEL_RESET = 6'h20;
	// infrared pulse width in sixteenths of a bit
	localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
	localparam logic [2:0] LAST_DATA_BIT = 3'h7;
	// transmitter states
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_START = 5'h02,
		ST_DATA = 5'h04,
		ST_PARITY = 5'h08,
		ST_STOP = 5'h10
	} uatx_state_t;
endpackage

// ==== hdl/uatx_top.sv ====
// uatx_top: serial transmit path with fifo, flow lines and clock pin
// How it works
// - nrz: high for mark, low for space
// - new character waits for clear-to-send low
// - negation mid-character finishes it, then holds
// - clear-to-send sampled by bit clock, readable
// - bypass ignores clear-to-send entirely
// - change flag on each toggle, optional interrupt
// - request line high when four free remain
// - request line manual level when flow unused
// - shared clock pin: input or single driver
// - empty fifo gives continuous idle level
// - start, data lsb first, parity, stop
// - line changes only on bit clock fall, except infrared pulse ends and break
// - space flag and interrupt; full writes dropped
// - fifo depth eight or sixty-four
// - empty interrupt once per complete drain
// - half interrupt: count or level marker
// - disabling transmit flushes, current char completes
// - busy holds until last character sent
// - send-break forces continuous zeros
// - parity inject sends wrong parity
// - infrared zero is short pulse, polarity bit
//
// Design decisions made here: the register addresses and the strobed register port.
module uatx_top
	import uatx_pkg::*;
#(
	parameter bit SECOND_PORT = 1'b0
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DW-1:0] rdata,
	input wire logic bit_clock,
	input wire logic sample_clock,
	output logic txd,
	input wire logic clear_to_send_n,
	output logic request_to_send_n,
	input wire logic [6:0] rx_free_slots,
	output logic rx_pulse_invert,
	input wire logic shared_serial_clock_pin_i,
	output logic shared_serial_clock_pin_o,
	output logic shared_serial_clock_pin_oe,
	input wire logic other_port_clk_drive,
	output logic clk_drive_claim,
	output logic baud_ext_clk,
	output logic irq_flow_change,
	output logic irq_space,
	output logic irq_empty,
	output logic irq_half
);
	localparam int DEPTH = SECOND_PORT ? DEPTH_SECOND : DEPTH_FIRST;
	localparam logic [6:0] DEPTH7 = 7'(DEPTH);

	// wrap a fifo index at the configured depth
	function automatic logic [5:0] next_ptr(input logic [5:0] p);
		next_ptr = (p == 6'(DEPTH - 1)) ? 6'h00 : p + 6'h01;
	endfunction

	// register state
	logic [15:0] ctrl_q;
	logic [4:0] misc_q;
	logic [5:0] level_q;
	logic break_q;
	logic bypass_q;
	logic flow_change_flag_q;
	logic clear_to_send_level_q;
	logic empty_evt_q;
	logic [DW-1:0] rdata_q;

	// fifo
	logic [7:0] mem_q [0:63];
	logic [5:0] wr_ptr_q;
	logic [5:0] rd_ptr_q;
	logic [6:0] cnt_q;

	// transmitter
	uatx_state_t st_q;
	uatx_state_t st_d;
	logic [7:0] shreg_q;
	logic [2:0] bitn_q;
	logic par_q;
	logic [3:0] pulse_cnt_q;
	logic txd_q;
	logic rts_n_q;
	logic shared_serial_clock_pin_o_q;
	logic shared_serial_clock_pin_oe_q;

	// synchronisers: s1 feeds only s2
	logic bclk_s1, bclk_s2, bclk_s3;
	logic sclk_s1, sclk_s2, sclk_s3;
	logic cts_s1, cts_s2;
	logic shared_serial_clock_pin_s1, shared_serial_clock_pin_s2;

	logic port_en, tx_en, ir_mode;
	logic bit_fall, bit_rise, tick16;
	logic tx_space_flag, busy, fifo_half;
	logic wr_ctrl, wr_tx, wr_misc, wr_level, wr_txcfg;
	logic push, pop, can_start, load;
	logic frame_bit, cur_bit, txd_d;

	assign port_en = ctrl_q[CT_PORT_EN];
	assign tx_en = ctrl_q[CT_TX_EN];
	assign ir_mode = ctrl_q[CT_IR];

	// pin and bit clock synchronisers, third stage for edges and the clock pin output
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			{bclk_s1, bclk_s2, bclk_s3} <= 3'h0;
			{sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
			{cts_s1, cts_s2} <= 2'h3;
			{shared_serial_clock_pin_s1, shared_serial_clock_pin_s2} <= 2'h0;
		end else if (clk_en) begin
			{bclk_s1, bclk_s2, bclk_s3} <= {bit_clock, bclk_s1, bclk_s2};
			{sclk_s1, sclk_s2, sclk_s3} <= {sample_clock, sclk_s1, sclk_s2};
			{cts_s1, cts_s2} <= {clear_to_send_n, cts_s1};
			{shared_serial_clock_pin_s1, shared_serial_clock_pin_s2} <= {shared_serial_clock_pin_i, shared_serial_clock_pin_s1};
		end
	end

	assign bit_fall = bclk_s3 & ~bclk_s2;
	assign bit_rise = ~bclk_s3 & bclk_s2;
	assign tick16 = ~sclk_s3 & sclk_s2;

	// bus decode
	assign wr_ctrl = wr && addr == ADDR_CTRL;
	assign wr_tx = wr && addr == ADDR_TX;
	assign wr_misc = wr && addr == ADDR_MISC;
	assign wr_level = wr && addr == ADDR_LEVEL;
	assign wr_txcfg = wr && addr == ADDR_TXCFG;

	// control registers written by software
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= CTRL_RESET;
			misc_q <= MISC_RESET;
			level_q <= LEVEL_RESET;
			break_q <= 1'b0;
			bypass_q <= 1'b0;
		end else if (clk_en) begin
			if (wr_ctrl)
				ctrl_q <= {6'h00, wdata[9:0]};
			if (wr_misc)
				misc_q <= wdata[4:0];
			if (wr_level)
				level_q <= wdata[5:0];
			if (wr_txcfg) begin
				break_q <= wdata[TC_BREAK];
				bypass_q <= wdata[TC_BYPASS];
			end
		end
	end

	// space flag drops when full or disabled; writes then vanish
	assign tx_space_flag = tx_en && cnt_q < DEPTH7;
	assign push = clk_en && wr_tx && tx_space_flag;
	assign can_start = port_en && tx_en && cnt_q != 7'h00
		&& (bypass_q || !clear_to_send_level_q);
	assign load = bit_fall && can_start && (st_q == ST_IDLE || st_q == ST_STOP);
	assign pop = clk_en && load;

	// fifo storage; depth set by port choice
	always_ff @(posedge clk) begin
		if (push)
			mem_q[wr_ptr_q] <= wdata[7:0];
	end

	// fifo pointers; clearing transmit enable flushes at once
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_q <= 6'h00;
			rd_ptr_q <= 6'h00;
			cnt_q <= 7'h00;
		end else if (clk_en) begin
			if (!tx_en) begin
				wr_ptr_q <= 6'h00;
				rd_ptr_q <= 6'h00;
				cnt_q <= 7'h00;
			end else begin
				if (push)
					wr_ptr_q <= next_ptr(wr_ptr_q);
				if (pop)
					rd_ptr_q <= next_ptr(rd_ptr_q);
				cnt_q <= cnt_q + 7'(push) - 7'(pop);
			end
		end
	end

	// fifo level events: empty fires once per full drain
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			empty_evt_q <= 1'b0;
		else if (clk_en) begin
			if (pop && !push && cnt_q == 7'h01)
				empty_evt_q <= 1'b1;
			else if (push)
				empty_evt_q <= 1'b0;
		end
	end

	assign fifo_half = SECOND_PORT ? (DEPTH7 - cnt_q) <= {1'b0, level_q}
		: cnt_q < HALF_FIRST;
	assign busy = st_q != ST_IDLE || cnt_q != 7'h00;

	// line sampling: level latched on bit clock, change flag sticky
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			clear_to_send_level_q <= 1'b1;
			flow_change_flag_q <= 1'b0;
		end else if (clk_en) begin
			if (bit_rise)
				clear_to_send_level_q <= cts_s2;
			// set wins over a clear in the same cycle
			if (bit_rise && cts_s2 != clear_to_send_level_q)
				flow_change_flag_q <= 1'b1;
			else if (wr_txcfg && wdata[TC_FLAG_CLR])
				flow_change_flag_q <= 1'b0;
		end
	end

	// frame sequencer, steps only on falling bit clock edges
	always_comb begin
		st_d = st_q;
		if (bit_fall) begin
			case (st_q)
				ST_IDLE: st_d = load ? ST_START : ST_IDLE;
				ST_START: st_d = ST_DATA;
				ST_DATA: begin
					if (bitn_q == LAST_DATA_BIT)
						st_d = ctrl_q[CT_PAR_EN] ? ST_PARITY : ST_STOP;
				end
				ST_PARITY: st_d = ST_STOP;
				ST_STOP: st_d = load ? ST_START : ST_IDLE;
				default: st_d = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			st_q <= ST_IDLE;
		else if (clk_en)
			st_q <= st_d;
	end

	// shifter, bit index and parity, loaded with each character
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shreg_q <= 8'h00;
			bitn_q <= 3'h0;
			par_q <= 1'b0;
		end else if (clk_en && bit_fall) begin
			if (load) begin
				shreg_q <= mem_q[rd_ptr_q];
				bitn_q <= 3'h0;
				// even parity unless odd chosen; inject flips it
				par_q <= ^mem_q[rd_ptr_q] ^ ctrl_q[CT_PAR_ODD] ^ misc_q[MS_PERR];
			end else if (st_q == ST_DATA) begin
				shreg_q <= {1'b0, shreg_q[7:1]};
				bitn_q <= bitn_q + 3'h1;
			end
		end
	end

	// infrared pulse timer: restarts at each bit boundary
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			pulse_cnt_q <= 4'hf;
		else if (clk_en) begin
			if (bit_fall)
				pulse_cnt_q <= 4'h0;
			else if (tick16 && pulse_cnt_q != 4'hf)
				pulse_cnt_q <= pulse_cnt_q + 4'h1;
		end
	end

	// line level: break overrides framing, idle is mark
	always_comb begin
		case (st_q)
			ST_START: frame_bit = 1'b0;
			ST_DATA: frame_bit = shreg_q[0];
			ST_PARITY: frame_bit = par_q;
			default: frame_bit = 1'b1;
		endcase
		cur_bit = break_q ? 1'b0 : frame_bit;
		if (ir_mode)
			txd_d = (!cur_bit && pulse_cnt_q < IR_PULSE_TICKS) ^ misc_q[MS_TX_INV];
		else
			txd_d = cur_bit;
	end

	// registered pins; request line is low when room remains
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			txd_q <= 1'b1;
			rts_n_q <= 1'b1;
			shared_serial_clock_pin_o_q <= 1'b0;
			shared_serial_clock_pin_oe_q <= 1'b0;
		end else if (clk_en) begin
			txd_q <= txd_d;
			if (misc_q[MS_RTS_MANUAL])
				rts_n_q <= misc_q[MS_RTS_LEVEL];
			else
				rts_n_q <= rx_free_slots <= RX_FREE_WARN;
			shared_serial_clock_pin_o_q <= bclk_s3;
			// never drive while the sibling port holds the pin
			shared_serial_clock_pin_oe_q <= ctrl_q[CT_CLK_OUT] && !other_port_clk_drive;
		end
	end

	// read port: data one cycle after the strobe, unmapped reads zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rdata_q <= 16'h0000;
		else if (clk_en) begin
			rdata_q <= 16'h0000;
			if (rd) begin
				case (addr)
					ADDR_CTRL: rdata_q <= ctrl_q;
					ADDR_TX: begin
						rdata_q[ST_SPACE] <= tx_space_flag;
						rdata_q[ST_BUSY] <= busy;
						rdata_q[ST_CTS] <= clear_to_send_level_q;
						rdata_q[ST_FLAG] <= flow_change_flag_q;
						rdata_q[ST_EMPTY] <= cnt_q == 7'h00;
						rdata_q[ST_HALF] <= fifo_half;
						rdata_q[ST_CNT +: 7] <= cnt_q;
					end
					ADDR_MISC: rdata_q <= {11'h000, misc_q};
					ADDR_LEVEL: rdata_q <= {10'h000, level_q};
					ADDR_TXCFG: rdata_q <= {14'h0000, bypass_q, break_q};
					default: rdata_q <= 16'h0000;
				endcase
			end
		end
	end

	// outputs
	assign rdata = rdata_q;
	assign txd = txd_q;
	assign request_to_send_n = rts_n_q;
	assign rx_pulse_invert = misc_q[MS_RX_INV];
	assign shared_serial_clock_pin_o = shared_serial_clock_pin_o_q;
	assign shared_serial_clock_pin_oe = shared_serial_clock_pin_oe_q;
	assign clk_drive_claim = ctrl_q[CT_CLK_OUT];
	assign baud_ext_clk = shared_serial_clock_pin_s2;
	assign irq_flow_change = flow_change_flag_q && ctrl_q[CT_FLOW_IE];
	assign irq_space = tx_space_flag && ctrl_q[CT_SPACE_IE];
	assign irq_empty = empty_evt_q && ctrl_q[CT_EMPTY_IE];
	assign irq_half = fifo_half && tx_en && ctrl_q[CT_HALF_IE];

	// checks
	chk_start_needs_cts: assert property (@(posedge clk) disable iff (!reset_n)
		(clk_en && st_q != ST_START && st_d == ST_START) |-> (bypass_q || !clear_to_send_level_q))
		else $error("character started without clear-to-send");
	chk_full_write_dropped: assert property (@(posedge clk) disable iff (!reset_n)
		(clk_en && wr_tx && cnt_q == DEPTH7 && !pop) |=> cnt_q == DEPTH7)
		else $error("write into full fifo was stored");
	chk_flush_on_disable: assert property (@(posedge clk) disable iff (!reset_n)
		(clk_en && !tx_en && !wr_ctrl) |=> (cnt_q == 7'h00 && !irq_space))
		else $error("fifo not flushed while transmit disabled");
	chk_break_zeros: assert property (@(posedge clk) disable iff (!reset_n)
		(clk_en && break_q && !ir_mode) |=> !txd)
		else $error("break did not drive zero");
	chk_idle_mark: assert property (@(posedge clk) disable iff (!reset_n)
		(clk_en && st_q == ST_IDLE && !break_q && !ir_mode) |=> txd)
		else $error("idle line not high");
	chk_busy_readback: assert property (@(posedge clk) disable iff (!reset_n)
		(clk_en && rd && addr == ADDR_TX && st_q != ST_IDLE) |=> rdata[ST_BUSY])
		else $error("busy clear during a frame");
	chk_rts_warning: assert property (@(posedge clk) disable iff (!reset_n)
		(clk_en && !misc_q[MS_RTS_MANUAL] && rx_free_slots <= RX_FREE_WARN) |=> request_to_send_n)
		else $error("request line not negated near full");
	chk_change_flag: assert property (@(posedge clk) disable iff (!reset_n)
		(clear_to_send_level_q != $past(clear_to_send_level_q)) |-> flow_change_flag_q)
		else $error("toggle did not set change flag");
	chk_change_on_fall: assert property (@(posedge clk) disable iff (!reset_n)
		(!$past(ir_mode) && !$past(ir_mode, 2) && !$past(break_q) && !$past(break_q, 2) && $changed(txd))
		|-> $past(bit_fall, 2))
		else $error("line changed away from bit clock fall");
	chk_clock_pin_single: assert property (@(posedge clk) disable iff (!reset_n)
		(clk_en && other_port_clk_drive) |=> !shared_serial_clock_pin_oe)
		else $error("clock pin driven with sibling driving");
endmodule

// ==== tb/uart_tx_flow_lines_tb_top.sv ====
// bench for the serial transmit path: registers, frames, flow lines
module uart_tx_flow_lines_tb_top
	import uatx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0, bit_clock = 1'b0, sample_clock = 1'b0, hold = 1'b0;
	logic [AW-1:0] addr = 8'h00;
	logic [DW-1:0] wdata = 16'h0000, rdata, d;
	logic [6:0] rx_free = 7'h10;
	logic txd, cts_n, rts_n, irq_e, irq_h, rx_tog;
	logic irq_f, irq_s, rx_inv, ck_o, ck_oe, ck_claim, ck_ext;
	logic ck_in = 1'b0, other_drv = 1'b0;
	logic [8:0] rx_word;
	logic [7:0] b;
	logic [8:0] exp_q[$];
	int n_mismatch = 0, comparisons = 0, cycles = 0, seed = 37;

	uatx_top #(.SECOND_PORT(1'b0)) uatx_top_inst (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bit_clock(bit_clock), .sample_clock(sample_clock),
		.txd(txd), .clear_to_send_n(cts_n), .request_to_send_n(rts_n), .rx_free_slots(rx_free),
		.rx_pulse_invert(rx_inv), .shared_serial_clock_pin_i(ck_in), .shared_serial_clock_pin_o(ck_o),
		.shared_serial_clock_pin_oe(ck_oe), .other_port_clk_drive(other_drv), .clk_drive_claim(ck_claim),
		.baud_ext_clk(ck_ext), .irq_flow_change(irq_f), .irq_space(irq_s), .irq_empty(irq_e), .irq_half(irq_h));
	uatx_line_model uatx_line_model_inst (.bit_clock(bit_clock), .txd(txd), .hold(hold),
		.clear_to_send_n(cts_n), .rx_word(rx_word), .rx_tog(rx_tog));

	// system clock, plus baud clocks at 64 and 4 system cycles, out of phase with it
	initial begin
		forever #25 clk = ~clk;
	end
	initial begin
		#7;
		forever #1600 bit_clock = ~bit_clock;
	end
	initial begin
		#3;
		forever #100 sample_clock = ~sample_clock;
	end

	task automatic finish_test();
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// hang guard, well above the roughly 15k cycles the sequence needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			n_mismatch++;
			finish_test();
		end
	end

	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe, so take it mid-cycle
	task automatic rchk(input string what, input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
		if (what != "")
			chk(what, e, d & m);
	endtask
	task automatic wait_idle();
		d = 16'h0002;
		for (int i = 0; i < 4000 && d[ST_BUSY] !== 1'b0; i++)
			rchk("", ADDR_TX, 16'h0000, 16'hffff);
		chk("busy wait", 16'h0000, {15'h0000, d[ST_BUSY]});
	endtask
	task automatic wait_start();
		for (int i = 0; i < 300 && txd !== 1'b0; i++)
			@(posedge clk);
		@(posedge clk);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	// ninth bit on the line: stop when parity is off, else even or odd parity
	function automatic logic ninth(input logic [7:0] v, input int m);
		return (m == 0) ? 1'b1 : ((^v) ^ (m == 2));
	endfunction
	task automatic send(input logic [7:0] v, input logic nb);
		exp_q.push_back({nb, v});
		wreg(ADDR_TX, {8'h00, v});
	endtask

	// every decoded frame is matched against the model queue in order
	always @(rx_tog) begin
		if (cycles > 0) begin
			if (exp_q.size() == 0)
				chk("stray frame", 16'h0000, {7'h00, rx_word});
			else
				chk("frame", {7'h00, exp_q.pop_front()}, {7'h00, rx_word});
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		settle(1);
		chk("txd idle", 16'h0001, {15'h0000, txd});
		rchk("ctrl reset", ADDR_CTRL, CTRL_RESET, 16'hffff);
		rchk("misc reset", ADDR_MISC, {11'h000, MISC_RESET}, 16'hffff);
		rchk("level reset", ADDR_LEVEL, {10'h000, LEVEL_RESET}, 16'hffff);
		rchk("unmapped", 8'h20, 16'h0000, 16'hffff);
		// back-to-back random bytes with parity off, even and odd
		for (int m = 0; m < 3; m++) begin
			wreg(ADDR_CTRL, 16'h00c3 | (m > 0 ? 16'h0008 : 16'h0000) | (m == 2 ? 16'h0010 : 16'h0000));
			for (int k = 0; k < 2; k++) begin
				b = 8'($random(seed));
				send(b, ninth(b, m));
			end
			wait_idle();
		end
		wreg(ADDR_MISC, 16'h0010);
		// odd parity is still selected here, so the injected bit is the inverse of odd
		send(8'h5a, ~ninth(8'h5a, 2));
		wait_idle();
		wreg(ADDR_MISC, 16'h0000);
		wreg(ADDR_CTRL, 16'h00c3);
		// negate clear-to-send during the first character: it completes, the second waits
		send(8'h3c, 1'b1);
		send(8'hc3, 1'b1);
		wait_start();
		hold <= 1'b1;
		settle(1500);
		chk("held frames", 16'h0001, 16'(exp_q.size()));
		wreg(ADDR_TXCFG, 16'h0002);
		wait_idle();
		chk("bypass frames", 16'h0000, 16'(exp_q.size()));
		wreg(ADDR_TXCFG, 16'h0000);
		// fill while held: the ninth write is dropped
		for (int i = 0; i < 9; i++) begin
			b = 8'($random(seed));
			if (i < 8)
				send(b, 1'b1);
			else
				wreg(ADDR_TX, {8'h00, b});
		end
		rchk("status full", ADDR_TX, 16'h080e, 16'hffff);
		wreg(ADDR_TXCFG, 16'h0004);
		@(posedge clk);
		hold <= 1'b0;
		wait_idle();
		rchk("status drained", ADDR_TX, 16'h0039, 16'hffff);
		chk("empty half irq", 16'h0003, {14'h0000, irq_e, irq_h});
		// change and space interrupts follow their enables; the flag clears on request
		wreg(ADDR_CTRL, 16'h01e3);
		settle(1);
		chk("flow space irq", 16'h0003, {14'h0000, irq_f, irq_s});
		wreg(ADDR_TXCFG, 16'h0004);
		settle(1);
		chk("flow irq cleared", 16'h0000, {15'h0000, irq_f});
		// dropping transmit enable flushes, the frame on the line completes
		send(8'h81, 1'b1);
		wreg(ADDR_TX, 16'h0042);
		wreg(ADDR_TX, 16'h0043);
		wait_start();
		wreg(ADDR_CTRL, 16'h00c1);
		rchk("flushed count", ADDR_TX, 16'h0000, 16'h7f00);
		wait_idle();
		// minimal break: enable cycled, break set, dummy loaded just after a rise, half a bit before a fall
		wreg(ADDR_CTRL, 16'h00c3);
		@(posedge bit_clock);
		wreg(ADDR_TXCFG, 16'h0001);
		exp_q.push_back(9'h000);
		wreg(ADDR_TX, 16'h00ff);
		wait_idle();
		wreg(ADDR_TXCFG, 16'h0000);
		// infrared with inverted pulses: idle high, each zero a short low pulse
		wreg(ADDR_MISC, 16'h0002);
		wreg(ADDR_CTRL, 16'h00c7);
		settle(2);
		chk("ir idle", 16'h0001, {15'h0000, txd});
		wreg(ADDR_TX, 16'h0000);
		wait_start();
		settle(0);
		chk("ir pulse", 16'h0000, {15'h0000, txd});
		settle(20);
		chk("ir pulse end", 16'h0001, {15'h0000, txd});
		wait_idle();
		wreg(ADDR_CTRL, 16'h00c3);
		wreg(ADDR_MISC, 16'h0000);
		// request line: flow use at the four-free threshold, then manual level
		rx_free <= 7'h05;
		settle(3);
		chk("request open", 16'h0000, {15'h0000, rts_n});
		@(posedge clk);
		rx_free <= 7'h04;
		settle(3);
		chk("request warn", 16'h0001, {15'h0000, rts_n});
		wreg(ADDR_MISC, 16'h0008);
		settle(3);
		chk("request manual low", 16'h0000, {15'h0000, rts_n});
		wreg(ADDR_MISC, 16'h000d);
		settle(3);
		chk("request manual high", 16'h0003, {14'h0000, rts_n, rx_inv});
		// clock pin: drive the bit clock out, yield to the sibling, pass the input through
		wreg(ADDR_CTRL, 16'h0201);
		settle(2);
		chk("clock pin claim", 16'h0006, {13'h0000, ck_claim, ck_oe, ck_ext});
		@(posedge bit_clock);
		settle(6);
		chk("clock pin high", 16'h0001, {15'h0000, ck_o});
		@(negedge bit_clock);
		settle(6);
		chk("clock pin low", 16'h0000, {15'h0000, ck_o});
		@(posedge clk);
		ck_in <= 1'b1;
		settle(3);
		chk("clock pin in", 16'h0001, {15'h0000, ck_ext});
		@(posedge clk);
		other_drv <= 1'b1;
		settle(2);
		chk("clock pin yield", 16'h0002, {14'h0000, ck_claim, ck_oe});
		settle(200);
		chk("pending frames", 16'h0000, 16'(exp_q.size()));
		finish_test();
	end
endmodule

// ==== tb/uatx_line_model.sv ====
// line-side partner: decodes the serial output and drives clear-to-send
module uatx_line_model (
	input wire logic bit_clock,
	input wire logic txd,
	input wire logic hold,
	output logic clear_to_send_n,
	output logic [8:0] rx_word,
	output logic rx_tog
);
	timeunit 1ns;
	timeprecision 1ns;
	int n = -1;
	logic [8:0] sh;
	initial begin
		rx_tog = 1'b0;
		rx_word = 9'h000;
		sh = 9'h000;
	end
	// far end asserts clear-to-send low unless the bench tells it to hold off
	assign clear_to_send_n = hold;
	// sample mid-bit on the rising bit clock, since the design moves txd on the fall
	always @(posedge bit_clock) begin
		if (n < 0) begin
			if (txd === 1'b0)
				n = 0;
		end else begin
			sh = {txd, sh[8:1]}; // lsb arrives first, ninth bit is parity or stop
			n = n + 1;
			if (n == 9) begin
				rx_word = sh;
				rx_tog = ~rx_tog;
				n = -1;
			end
		end
	end
endmodule
